// >>> hdl/channel_event_unit.sv
// event flags, alarm copy and error count of one channel
// assumes alarm levels come from detectors on the same clock
`timescale 1ns/1ps
module channel_event_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] alarm_i,
  input wire logic pattern_error_i,
  input wire logic [7:0] irq_enable_i,
  input wire logic jitter_enabled_i,
  input wire logic flags_read_i,
  output logic [7:0] flags_o,
  output logic [7:0] alarm_o,
  output logic [15:0] count_o,
  output logic irq_o
);

  logic [7:0] set_vec;
  logic [7:0] next_flags;

  // ==========================================================
  // edge and count decode
  wire [7:0] change = {1'b0, alarm_i} ^ alarm_o;
  wire count_at_max = (count_o == liu_regs_pkg::COUNT_MAX);
  wire count_saturates = pattern_error_i && (count_o == liu_regs_pkg::COUNT_MAX - 16'h1);
  wire [15:0] next_count = (pattern_error_i && !count_at_max) ? count_o + 16'h1 : count_o;

  always_comb begin
    set_vec = 8'h00;
    set_vec[liu_regs_pkg::BIT_DRIVER_QUIET] = change[liu_regs_pkg::BIT_DRIVER_QUIET]
      && irq_enable_i[liu_regs_pkg::BIT_DRIVER_QUIET]; // see RL2 see RL8
    set_vec[liu_regs_pkg::BIT_RX_SIGNAL_LOSS] = change[liu_regs_pkg::BIT_RX_SIGNAL_LOSS]
      && irq_enable_i[liu_regs_pkg::BIT_RX_SIGNAL_LOSS]; // see RL3 see RL9
    set_vec[liu_regs_pkg::BIT_RX_LOCK_LOSS] = change[liu_regs_pkg::BIT_RX_LOCK_LOSS]
      && irq_enable_i[liu_regs_pkg::BIT_RX_LOCK_LOSS]; // see RL4 see RL10 see RL11
    set_vec[liu_regs_pkg::BIT_FIFO_LIMIT] = change[liu_regs_pkg::BIT_FIFO_LIMIT]
      && irq_enable_i[liu_regs_pkg::BIT_FIFO_LIMIT] && jitter_enabled_i; // see RL5 see RL12
    set_vec[liu_regs_pkg::BIT_PATTERN_ERROR] = pattern_error_i
      && irq_enable_i[liu_regs_pkg::BIT_PATTERN_ERROR]; // see RL6 see RL13
    set_vec[liu_regs_pkg::BIT_PATTERN_COUNT_FULL] = count_saturates
      && irq_enable_i[liu_regs_pkg::BIT_PATTERN_COUNT_FULL]; // see RL7 see RL14
  end

  // set wins over the read clear
  assign next_flags = ((flags_read_i ? 8'h00 : flags_o) | set_vec)
    & liu_regs_pkg::MASK_FLAGS; // see RL15

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= liu_regs_pkg::RESET_REG;
      alarm_o <= liu_regs_pkg::RESET_REG;
      count_o <= 16'h0000;
      irq_o <= 1'b0;
    end else begin
      flags_o <= next_flags;
      alarm_o <= {1'b0, alarm_i};
      count_o <= next_count; // see RL14 see RL15
      irq_o <= |(next_flags & irq_enable_i & liu_regs_pkg::MASK_FLAGS); // see RL16
    end
  end

endmodule : channel_event_unit

// >>> hdl/host_port_strobe.sv
// strobe handling of the parallel processor port
// assumes chip select and strobes are synchronous to clk_i
`timescale 1ns/1ps
module host_port_strobe (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic read_go_o,
  output logic write_go_o,
  output logic read_active_o,
  output logic ready_o
);

  typedef enum logic [1:0] {IDLE, WAIT, DONE} port_state_t;

  port_state_t state;
  port_state_t next_state;
  logic [1:0] wait_count;
  logic [1:0] next_wait_count;

  localparam logic [1:0] ACCESS_CYCLES_M1 = liu_regs_pkg::ACCESS_CYCLES - 2'h1;

  // ==========================================================
  // strobe decode
  wire rd_req = !cs_n_i && !rd_n_i;
  wire wr_req = !cs_n_i && !wr_n_i && rd_n_i;
  wire any_req = rd_req || wr_req;
  wire start = (state == IDLE) && any_req;

  always_comb begin
    next_state = state;
    next_wait_count = wait_count;
    case (state)
      IDLE: begin
        if (any_req) begin
          next_state = WAIT;
          next_wait_count = ACCESS_CYCLES_M1;
        end
      end
      WAIT: begin
        if (!any_req) begin
          next_state = IDLE;
        end else if (wait_count == 2'h0) begin
          next_state = DONE;
        end else begin
          next_wait_count = wait_count - 2'h1;
        end
      end
      DONE: begin
        if (!any_req) begin
          next_state = IDLE;
        end
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= IDLE;
      wait_count <= 2'h0;
      read_go_o <= 1'b0;
      write_go_o <= 1'b0;
      read_active_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      state <= next_state;
      wait_count <= next_wait_count;
      read_go_o <= start && rd_req;
      write_go_o <= start && wr_req;
      read_active_o <= rd_req;
      ready_o <= (next_state == DONE);
    end
  end

endmodule : host_port_strobe

// >>> hdl/liu_channel_regs_irq.sv
// per-channel register group of a six-channel line interface
// assumes a synchronous parallel processor port on clk_i
//
// How it works
// RL1 - six channel groups at base 0x10 times channel
// RL2 - driver quiet change flags only when enabled
// RL3 - enable bit 1 gates signal loss interrupt
// RL4 - enable bit 2 gates lock loss interrupt
// RL5 - enable bit 3 gates fifo limit, needs attenuator
// RL6 - enable bit 4 gates pattern bit error
// RL7 - enable bit 5 gates error count saturation
// RL8 - driver quiet flag set on both transitions
// RL9 - signal loss flag set on both transitions
// RL10 - lock loss entry sets flag when enabled
// RL11 - return to lock sets flag again
// RL12 - fifo limit entry and exit set flag
// RL13 - pattern bit error sets status bit 4
// RL14 - sixteen bit error count, saturation sets bit 5
// RL15 - status read clears; counter holds at maximum
// RL16 - channel request while any enabled flag set
`timescale 1ns/1ps
module liu_channel_regs_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ready_o,
  input wire logic [5:0] driver_quiet_alarm_i,
  input wire logic [5:0] rx_signal_loss_alarm_i,
  input wire logic [5:0] rx_lock_loss_alarm_i,
  input wire logic [5:0] fifo_limit_alarm_i,
  input wire logic [5:0] analog_signal_loss_alarm_i,
  input wire logic [5:0] digital_signal_loss_alarm_i,
  input wire logic [5:0] pattern_sync_loss_alarm_i,
  input wire logic [5:0] pattern_error_i,
  output logic [5:0] channel_irq_o,
  output logic [47:0] transmit_setup_o,
  output logic [47:0] receive_setup_o,
  output logic [47:0] channel_mode_setup_o,
  output logic [47:0] jitter_fifo_setup_o
);

  // ==========================================================
  // storage
  logic [7:0] channel_irq_enable [liu_regs_pkg::NUM_CH];
  logic [7:0] transmit_setup [liu_regs_pkg::NUM_CH];
  logic [7:0] receive_setup [liu_regs_pkg::NUM_CH];
  logic [7:0] channel_mode_setup [liu_regs_pkg::NUM_CH];
  logic [7:0] jitter_fifo_setup [liu_regs_pkg::NUM_CH];
  logic [7:0] channel_irq_flags [liu_regs_pkg::NUM_CH];
  logic [7:0] channel_alarm_state [liu_regs_pkg::NUM_CH];
  logic [15:0] pattern_error_count [liu_regs_pkg::NUM_CH];
  logic [5:0] flags_read;
  logic [7:0] read_value;

  logic read_go;
  logic write_go;
  logic read_active;
  logic port_ready;

  // ==========================================================
  // address decode
  function automatic logic channel_valid(input logic [7:0] addr);
    channel_valid = (addr[7] == 1'b0) && (addr[6:4] < 3'(liu_regs_pkg::NUM_CH));
  endfunction : channel_valid

  function automatic logic [7:0] pick(input logic [7:0] value, input logic [7:0] mask);
    pick = value & mask;
  endfunction : pick

  wire [2:0] sel_ch = addr_i[6:4]; // see RL1
  wire [3:0] sel_ofs = addr_i[3:0];
  wire addr_ok = channel_valid(addr_i);

  // one select per written or read-cleared offset, each feeding one write or read-clear strobe
  wire sel_is_enable = addr_ok && (sel_ofs == liu_regs_pkg::OFS_IRQ_ENABLE);
  wire sel_is_flags = addr_ok && (sel_ofs == liu_regs_pkg::OFS_IRQ_FLAGS);
  wire sel_is_transmit = addr_ok && (sel_ofs == liu_regs_pkg::OFS_TRANSMIT_SETUP);
  wire sel_is_receive = addr_ok && (sel_ofs == liu_regs_pkg::OFS_RECEIVE_SETUP);
  wire sel_is_mode = addr_ok && (sel_ofs == liu_regs_pkg::OFS_MODE_SETUP);
  wire sel_is_jitter = addr_ok && (sel_ofs == liu_regs_pkg::OFS_JITTER_SETUP);

  wire wr_enable = write_go && sel_is_enable;
  wire wr_transmit = write_go && sel_is_transmit;
  wire wr_receive = write_go && sel_is_receive;
  wire wr_mode = write_go && sel_is_mode;
  wire wr_jitter = write_go && sel_is_jitter;
  wire rd_flags = read_go && sel_is_flags;

  // ==========================================================
  // processor port strobes
  host_port_strobe port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cs_n_i(cs_n_i),
    .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i),
    .read_go_o(read_go),
    .write_go_o(write_go),
    .read_active_o(read_active),
    .ready_o(port_ready)
  );

  // ==========================================================
  // per-channel event logic
  genvar ch;
  generate
    for (ch = 0; ch < liu_regs_pkg::NUM_CH; ch++) begin : g_ch
      // alarm levels packed in alarm register bit order
      wire [6:0] alarms = {
        pattern_sync_loss_alarm_i[ch],
        digital_signal_loss_alarm_i[ch],
        analog_signal_loss_alarm_i[ch],
        fifo_limit_alarm_i[ch],
        rx_lock_loss_alarm_i[ch],
        rx_signal_loss_alarm_i[ch],
        driver_quiet_alarm_i[ch]
      };
      wire ch_hit = (sel_ch == 3'(ch)); // see RL1
      // attenuator off when both select bits clear
      wire ja_on = jitter_fifo_setup[ch][liu_regs_pkg::BIT_JA_SELECT0]
        || jitter_fifo_setup[ch][liu_regs_pkg::BIT_JA_SELECT1]; // see RL5
      assign flags_read[ch] = rd_flags && ch_hit; // see RL15

      channel_event_unit unit (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .alarm_i(alarms),
        .pattern_error_i(pattern_error_i[ch]),
        .irq_enable_i(channel_irq_enable[ch]),
        .jitter_enabled_i(ja_on),
        .flags_read_i(flags_read[ch]),
        .flags_o(channel_irq_flags[ch]),
        .alarm_o(channel_alarm_state[ch]),
        .count_o(pattern_error_count[ch]),
        .irq_o(channel_irq_o[ch])
      );

      assign transmit_setup_o[ch*8 +: 8] = transmit_setup[ch];
      assign receive_setup_o[ch*8 +: 8] = receive_setup[ch];
      assign channel_mode_setup_o[ch*8 +: 8] = channel_mode_setup[ch];
      assign jitter_fifo_setup_o[ch*8 +: 8] = jitter_fifo_setup[ch];
    end
  endgenerate

  // ==========================================================
  // read-back selection, unmapped reads return zero
  wire [7:0] rb_enable = pick(channel_irq_enable[sel_ch], liu_regs_pkg::MASK_IRQ_ENABLE);
  wire [7:0] rb_flags = pick(channel_irq_flags[sel_ch], liu_regs_pkg::MASK_FLAGS);
  wire [7:0] rb_alarm = pick(channel_alarm_state[sel_ch], liu_regs_pkg::MASK_ALARM);
  wire [7:0] rb_transmit = pick(transmit_setup[sel_ch], liu_regs_pkg::MASK_TRANSMIT);
  wire [7:0] rb_receive = pick(receive_setup[sel_ch], liu_regs_pkg::MASK_RECEIVE);
  wire [7:0] rb_mode = pick(channel_mode_setup[sel_ch], liu_regs_pkg::MASK_MODE);
  wire [7:0] rb_jitter = pick(jitter_fifo_setup[sel_ch], liu_regs_pkg::MASK_JITTER);
  wire [7:0] rb_count_high = pattern_error_count[sel_ch][15:8]; // see RL14
  wire [7:0] rb_count_low = pattern_error_count[sel_ch][7:0]; // see RL14

  always_comb begin
    read_value = 8'h00;
    if (addr_ok) begin
      case (sel_ofs)
        liu_regs_pkg::OFS_IRQ_ENABLE: begin
          read_value = rb_enable;
        end
        liu_regs_pkg::OFS_IRQ_FLAGS: begin
          read_value = rb_flags;
        end
        liu_regs_pkg::OFS_ALARM_STATE: begin
          read_value = rb_alarm;
        end
        liu_regs_pkg::OFS_TRANSMIT_SETUP: begin
          read_value = rb_transmit;
        end
        liu_regs_pkg::OFS_RECEIVE_SETUP: begin
          read_value = rb_receive;
        end
        liu_regs_pkg::OFS_MODE_SETUP: begin
          read_value = rb_mode;
        end
        liu_regs_pkg::OFS_JITTER_SETUP: begin
          read_value = rb_jitter;
        end
        liu_regs_pkg::OFS_COUNT_HIGH: begin
          read_value = rb_count_high; // see RL14
        end
        liu_regs_pkg::OFS_COUNT_LOW: begin
          read_value = rb_count_low; // see RL14
        end
        default: begin
          read_value = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // writable registers
  // interrupt enables
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < liu_regs_pkg::NUM_CH; i++) begin
        channel_irq_enable[i] <= liu_regs_pkg::RESET_REG;
      end
    end else if (wr_enable) begin
      channel_irq_enable[sel_ch] <= pick(data_i, liu_regs_pkg::MASK_IRQ_ENABLE);
    end
  end

  // transmit setup
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < liu_regs_pkg::NUM_CH; i++) begin
        transmit_setup[i] <= liu_regs_pkg::RESET_REG;
      end
    end else if (wr_transmit) begin
      transmit_setup[sel_ch] <= pick(data_i, liu_regs_pkg::MASK_TRANSMIT);
    end
  end

  // receive setup
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < liu_regs_pkg::NUM_CH; i++) begin
        receive_setup[i] <= liu_regs_pkg::RESET_REG;
      end
    end else if (wr_receive) begin
      receive_setup[sel_ch] <= pick(data_i, liu_regs_pkg::MASK_RECEIVE);
    end
  end

  // channel mode setup
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < liu_regs_pkg::NUM_CH; i++) begin
        channel_mode_setup[i] <= liu_regs_pkg::RESET_REG;
      end
    end else if (wr_mode) begin
      channel_mode_setup[sel_ch] <= pick(data_i, liu_regs_pkg::MASK_MODE);
    end
  end

  // jitter fifo setup, also gates the fifo limit flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < liu_regs_pkg::NUM_CH; i++) begin
        jitter_fifo_setup[i] <= liu_regs_pkg::RESET_REG;
      end
    end else if (wr_jitter) begin
      jitter_fifo_setup[sel_ch] <= pick(data_i, liu_regs_pkg::MASK_JITTER);
    end
  end

  // ==========================================================
  // data bus and ready
  // read data, held until the next read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
    end else if (read_go) begin
      data_o <= read_value; // see RL15
    end
  end

  // bus drive only while the read strobe stands
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= read_active && !cs_n_i && !rd_n_i;
    end
  end

  // answer one clock behind the strobe unit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= port_ready;
    end
  end

endmodule : liu_channel_regs_irq

// >>> hdl/liu_regs_pkg.sv
// constants for the six-channel line interface register group
// assumes one processor-port clock and one asynchronous active-high reset
package liu_regs_pkg;

  // ==========================================================
  // channel layout
  localparam int NUM_CH = 6;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] OFS_IRQ_FLAGS = 4'h2;
  localparam logic [3:0] OFS_ALARM_STATE = 4'h3;
  localparam logic [3:0] OFS_TRANSMIT_SETUP = 4'h4;
  localparam logic [3:0] OFS_RECEIVE_SETUP = 4'h5;
  localparam logic [3:0] OFS_MODE_SETUP = 4'h6;
  localparam logic [3:0] OFS_JITTER_SETUP = 4'h7;
  localparam logic [3:0] OFS_COUNT_HIGH = 4'ha;
  localparam logic [3:0] OFS_COUNT_LOW = 4'hb;

  // ==========================================================
  // field positions of the enable, flag and alarm registers and of the jitter fifo setup
  localparam int BIT_DRIVER_QUIET = 0;
  localparam int BIT_RX_SIGNAL_LOSS = 1;
  localparam int BIT_RX_LOCK_LOSS = 2;
  localparam int BIT_FIFO_LIMIT = 3;
  localparam int BIT_PATTERN_ERROR = 4;
  localparam int BIT_PATTERN_COUNT_FULL = 5;
  localparam int BIT_ANALOG_SIGNAL_LOSS = 4;
  localparam int BIT_DIGITAL_SIGNAL_LOSS = 5;
  localparam int BIT_PATTERN_SYNC_LOSS = 6;
  localparam int BIT_JA_SELECT0 = 0;
  localparam int BIT_JA_SELECT1 = 2;

  // ==========================================================
  // implemented register bits, reset values and error count maximum
  localparam logic [7:0] MASK_IRQ_ENABLE = 8'h3f;
  localparam logic [7:0] MASK_FLAGS = 8'h3f;
  localparam logic [7:0] MASK_ALARM = 8'h7f;
  localparam logic [7:0] MASK_TRANSMIT = 8'h37;
  localparam logic [7:0] MASK_RECEIVE = 8'h3f;
  localparam logic [7:0] MASK_MODE = 8'h7f;
  localparam logic [7:0] MASK_JITTER = 8'h1f;
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // ==========================================================
  // port timing: two processor clocks of access wait, ready_o answers on the fourth rising edge after the strobe
  localparam int ACCESS_NS = 20;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [1:0] ACCESS_CYCLES = 2'(ACCESS_NS / CLK_PERIOD_NS);

endpackage : liu_regs_pkg

// >>> test/host_bus_model.sv
// host processor model for the parallel register port
// assumes the device samples strobes on the rising edge of clk_i
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic ready_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 8'h00;
    wdata_o = 8'h5a;
  end
  // ====================
  // one access, held until ready is sampled high or 16 clocks have passed
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    addr_o = a;
    wdata_o = d;
    rd_n_o = ~rd;
    wr_n_o = rd;
    do begin
      @(posedge clk_i);
      n++;
    end while (ready_i !== 1'b1 && n < 16);
    ok = (ready_i === 1'b1);
    q = rdata_i;
    @(negedge clk_i);
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    // released data lines must not keep the written value
    wdata_o = ~wdata_o;
    repeat (2) @(negedge clk_i);
  endtask : access
endmodule : host_bus_model

// >>> test/liu_regs_properties.sv
// assertions on the register port and interrupt outputs
// assumes binding to liu_channel_regs_irq, one clock, reset active high
`timescale 1ns/1ps
module liu_regs_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic ready_o,
  input wire logic [5:0] driver_quiet_alarm_i,
  input wire logic [5:0] rx_signal_loss_alarm_i,
  input wire logic [5:0] rx_lock_loss_alarm_i,
  input wire logic [5:0] fifo_limit_alarm_i,
  input wire logic [5:0] pattern_error_i,
  input wire logic [5:0] channel_irq_o,
  input wire logic [47:0] transmit_setup_o,
  input wire logic [47:0] receive_setup_o,
  input wire logic [47:0] channel_mode_setup_o,
  input wire logic [47:0] jitter_fifo_setup_o
);
  // ====================
  // per-channel flag source event
  logic [23:0] prev;
  logic [5:0] chg;
  logic [191:0] setups;
  assign setups = {transmit_setup_o, receive_setup_o, channel_mode_setup_o, jitter_fifo_setup_o};
  assign chg = (driver_quiet_alarm_i ^ prev[5:0]) | (rx_signal_loss_alarm_i ^ prev[11:6])
    | (rx_lock_loss_alarm_i ^ prev[17:12]) | (fifo_limit_alarm_i ^ prev[23:18]) | pattern_error_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev <= 24'h000000;
    end else begin
      prev <= {fifo_limit_alarm_i, rx_lock_loss_alarm_i, rx_signal_loss_alarm_i,
        driver_quiet_alarm_i};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  // port and interrupt relations
  a_read_ack_time: assert property (
    $fell(rd_n_i) && !cs_n_i |-> !ready_o [*3] ##[1:2] ready_o) else $error("read ack timing");
  a_write_ack_time: assert property (
    $fell(wr_n_i) && !cs_n_i && rd_n_i |-> !ready_o [*3] ##[1:2] ready_o)
    else $error("write ack timing");
  a_ready_needs_select: assert property (
    ready_o |-> $past(!cs_n_i) || $past(!cs_n_i, 2)) else $error("ready without select");
  a_drive_on_read: assert property (
    data_oe_o |-> $past(!rd_n_i) || $past(!rd_n_i, 2) || $past(!rd_n_i, 3))
    else $error("bus driven outside read");
  a_no_drive_write: assert property (
    (!wr_n_i && rd_n_i) [*3] |-> !data_oe_o) else $error("bus driven during write");
  a_read_data_hold: assert property (
    !$stable(data_o) |-> $past(!rd_n_i)) else $error("read data moved without read");
  a_setup_by_write: assert property (
    !$stable(setups) |-> $past(!wr_n_i) || $past(!wr_n_i, 2)) else $error("setup moved");
  a_irq_rise_cause: assert property (
    |(channel_irq_o & ~$past(channel_irq_o)) |-> |($past(chg) | $past(chg, 2))
    || $past(!wr_n_i) || $past(!wr_n_i, 2)) else $error("request without event");
  a_irq_fall_cause: assert property (
    |(~channel_irq_o & $past(channel_irq_o)) |-> $past(!cs_n_i) || $past(!cs_n_i, 2))
    else $error("request dropped without access");
endmodule : liu_regs_properties

bind liu_channel_regs_irq liu_regs_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .ready_o(ready_o),
  .driver_quiet_alarm_i(driver_quiet_alarm_i), .rx_signal_loss_alarm_i(rx_signal_loss_alarm_i),
  .rx_lock_loss_alarm_i(rx_lock_loss_alarm_i), .fifo_limit_alarm_i(fifo_limit_alarm_i),
  .pattern_error_i(pattern_error_i), .channel_irq_o(channel_irq_o),
  .transmit_setup_o(transmit_setup_o), .receive_setup_o(receive_setup_o),
  .channel_mode_setup_o(channel_mode_setup_o), .jitter_fifo_setup_o(jitter_fifo_setup_o)
);

// >>> test/tb_liu_channel_regs_irq.sv
// self-checking bench for the per-channel register group
// assumes host_bus_model and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module tb_liu_channel_regs_irq;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, rd_n, wr_n, oe, rdy;
  logic [7:0] addr, wdata, dout, rdata, q;
  logic [5:0] src [8];
  logic [5:0] irq;
  logic [47:0] txs, rxs, mds, jas;
  int fail_count = 0;
  int samples_checked = 0;
  assign rdata = oe ? dout : 8'hxx;
  initial begin
    foreach (src[k]) src[k] = 6'h00;
    forever #5 clk = ~clk;
  end
  host_bus_model host (.clk_i(clk), .rdata_i(rdata), .ready_i(rdy), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
  liu_channel_regs_irq DUT (
    .clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .addr_i(addr), .data_i(wdata), .data_o(dout), .data_oe_o(oe), .ready_o(rdy),
    .driver_quiet_alarm_i(src[0]), .rx_signal_loss_alarm_i(src[1]),
    .rx_lock_loss_alarm_i(src[2]), .fifo_limit_alarm_i(src[3]), .pattern_error_i(src[4]),
    .analog_signal_loss_alarm_i(src[5]), .digital_signal_loss_alarm_i(src[6]),
    .pattern_sync_loss_alarm_i(src[7]), .channel_irq_o(irq), .transmit_setup_o(txs),
    .receive_setup_o(rxs), .channel_mode_setup_o(mds), .jitter_fifo_setup_o(jas));
  // ====================
  // bus helpers
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.access(rd, a, d, q, ok);
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t no ready", $time);
      summarize();
    end
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b1, a, 8'h00);
    `CHK(q, e)
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask : wr
  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  // ====================
  // scenarios
  task automatic t_map();
    logic [3:0] ofs [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb};
    logic [7:0] msk [9] = '{8'h3f, 8'h00, 8'h00, 8'h37, 8'h3f, 8'h7f, 8'h1f, 8'h00, 8'h00};
    logic [7:0] u [4] = '{8'h08, 8'h0c, 8'h71, 8'h81};
    for (int c = 0; c < 6; c++) begin
      for (int i = 0; i < 9; i++) begin
        rd_chk({1'b0, 3'(c), ofs[i]}, 8'h00);
        wr({1'b0, 3'(c), ofs[i]}, 8'hff);
        rd_chk({1'b0, 3'(c), ofs[i]}, msk[i]);
      end
      `CHK({jas[8*c+:8], mds[8*c+:8], rxs[8*c+:8], txs[8*c+:8]}, 32'h1f7f3f37)
    end
    foreach (u[i]) begin
      wr(u[i], 8'h2a);
      rd_chk(u[i], 8'h00);
    end
    rd_chk(8'h01, 8'h3f);
  endtask : t_map
  task automatic t_events(input int c, input logic [7:0] en, input logic [7:0] ja);
    logic [7:0] a;
    logic [7:0] e;
    a = {1'b0, 3'(c), 4'h0};
    wr(a | 8'h07, ja);
    wr(a | 8'h01, en);
    for (int b = 0; b < 5; b++) begin
      e = en & 8'(1 << b) & ((ja[0] | ja[2]) ? 8'hff : 8'hf7);
      repeat (2) begin
        @(negedge clk);
        src[b][c] = ~src[b][c];
        @(negedge clk);
        src[4][c] = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(irq[c], |e)
        rd_chk(a | 8'h02, e);
        `CHK(irq[c], 1'b0)
        rd_chk(a | 8'h02, 8'h00);
      end
    end
    src[5][c] = 1'b1;
    src[7][c] = 1'b1;
    rd_chk(a | 8'h03, 8'h50);
    rd_chk(a | 8'h02, 8'h00);
    src[5][c] = 1'b0;
    src[7][c] = 1'b0;
  endtask : t_events
  task automatic t_count();
    wr(8'h31, 8'h30);
    @(negedge clk);
    src[4][3] = 1'b1;
    repeat (65534) @(negedge clk);
    src[4][3] = 1'b0;
    rd_chk(8'h3a, 8'hff);
    rd_chk(8'h3b, 8'hfe);
    rd_chk(8'h32, 8'h10);
    src[4][3] = 1'b1;
    repeat (4) @(negedge clk);
    src[4][3] = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(irq[3], 1'b1)
    rd_chk(8'h32, 8'h30);
    rd_chk(8'h3a, 8'hff);
    rd_chk(8'h3b, 8'hff);
  endtask : t_count
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  initial begin
    do_reset();
    t_map();
    do_reset();
    `CHK({jas, mds, rxs, txs}, 192'h0)
    t_events(0, 8'h3f, 8'h01);
    t_events(2, 8'h15, 8'h04);
    t_events(4, 8'h2a, 8'h00);
    t_events(5, 8'h00, 8'h05);
    t_count();
    summarize();
  end
endmodule : tb_liu_channel_regs_irq
